// >>> hdl/wdr_watchdog.v
`include "wdr_defs.vh"

module wdr_watchdog (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`WDR_ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`WDR_ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire                    sub_clk_pin,
  input  wire                    osc_clk_pin,
  input  wire [2:0]              power_mode,
  output reg                     chip_reset_n,
  output wire                    module_standby
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_PULSE = 2'h2;

  // decode of a byte address to a register select
  function [2:0] reg_sel;
    input [`WDR_ADDR_W-1:0] a;
    begin
      if (a == {`WDR_IDX_CTRL, 2'b00})
        reg_sel = 3'h1;
      else if (a == {`WDR_IDX_COUNT, 2'b00})
        reg_sel = 3'h2;
      else if (a == {`WDR_IDX_PORT_SEL, 2'b00})
        reg_sel = 3'h3;
      else if (a == {`WDR_IDX_CLK_GATE, 2'b00})
        reg_sel = 3'h4;
      else
        reg_sel = 3'h0;
    end
  endfunction

  reg  [7:0]               watchdog_count;
  reg                      count_write_enable;
  reg                      reg_write_enable;
  reg                      watchdog_run;
  reg                      reset_occurred_flag;
  reg  [7:0]               port_function_select_three;
  reg  [7:0]               module_clock_gate_two;
  reg  [`WDR_SYS_DIV_W-1:0] sys_div;
  reg  [`WDR_SUB_DIV_W-1:0] sub_div;
  reg                      sys_tick;
  reg                      sub_tick;
  reg  [1:0]               rst_state;
  reg  [`WDR_RST_CNT_W-1:0] osc_count;
  reg  [`WDR_ADDR_W-1:0]   aw_addr;
  reg                      aw_held;
  reg  [7:0]               w_data;
  reg                      w_lane0;
  reg                      w_held;
  reg  [7:0]               rd_val;

  wire [1:0] pin_rise;
  wire [1:0] pin_in;
  assign pin_in = {osc_clk_pin, sub_clk_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      wdr_pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (pin_in[gi]),
        .level   (),
        .rise    (pin_rise[gi])
      );
    end
  endgenerate

  wire sub_edge = pin_rise[0];
  wire osc_edge = pin_rise[1];
  // whole-chip reset from overflow or the pin reset, shared by everything but the flag, the chip reset sequencer and the pin synchronizers
  wire int_rst  = !aresetn || (rst_state == ST_PULSE);
  wire src_sub  = port_function_select_three[`WDR_B_SRC_SEL];
  wire base_sub = (power_mode == `WDR_MODE_SUBACTIVE);

  assign module_standby = !module_clock_gate_two[`WDR_B_STANDBY] && !watchdog_run;

  always @(posedge aclk) begin
    if (int_rst) begin
      sys_div  <= {`WDR_SYS_DIV_W{1'b0}};
      sub_div  <= {`WDR_SUB_DIV_W{1'b0}};
      sys_tick <= 1'b0;
      sub_tick <= 1'b0;
    end else begin
      sys_div  <= sys_div + 1'b1;
      sys_tick <= (sys_div == {`WDR_SYS_DIV_W{1'b1}});
      sub_tick <= 1'b0;
      if (sub_edge) begin
        sub_div  <= sub_div + 1'b1;
        sub_tick <= (sub_div == {`WDR_SUB_DIV_W{1'b1}});
      end
    end
  end

  reg mode_ok;
  always @* begin
    case (power_mode)
      `WDR_MODE_ACTIVE:    mode_ok = 1'b1;
      `WDR_MODE_SLEEP:     mode_ok = 1'b1;
      `WDR_MODE_SUBACTIVE: mode_ok = src_sub;
      default:             mode_ok = 1'b0;
    endcase
  end

  wire sel_tick = src_sub ? sub_tick : sys_tick;
  wire count_tick = sel_tick && watchdog_run && mode_ok && !module_standby;
  wire overflow = count_tick && (watchdog_count == 8'hFF) && (rst_state == ST_IDLE);

  // axi write channel
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [2:0] wsel = reg_sel(aw_addr);

  always @(posedge aclk) begin
    if (int_rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {`WDR_ADDR_W{1'b0}};
      w_data       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WDR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 3'h0) ? `WDR_RESP_SLVERR : `WDR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_ctrl  = do_write && w_lane0 && (wsel == 3'h1);
  wire wr_count = do_write && w_lane0 && (wsel == 3'h2);
  wire wr_port  = do_write && w_lane0 && (wsel == 3'h3);
  wire wr_gate  = do_write && w_lane0 && (wsel == 3'h4);

  always @(posedge aclk) begin
    if (int_rst) begin
      count_write_enable         <= 1'b0;
      reg_write_enable           <= 1'b0;
      watchdog_run               <= 1'b0;
      watchdog_count             <= `WDR_RST_COUNT;
      port_function_select_three <= `WDR_RST_PORT_SEL;
      module_clock_gate_two      <= `WDR_RST_CLK_GATE;
    end else begin
      if (wr_ctrl) begin
        if (!w_data[`WDR_B_CNT_INH])
          count_write_enable <= w_data[`WDR_B_CNT_WE];
        if (!w_data[`WDR_B_REG_INH])
          reg_write_enable <= w_data[`WDR_B_REG_WE];
        if (reg_write_enable && !w_data[`WDR_B_RUN_INH])
          watchdog_run <= w_data[`WDR_B_RUN];
      end
      // guarded count write; resumes from it
      if (wr_count && count_write_enable)
        watchdog_count <= w_data;
      else if (count_tick)
        watchdog_count <= watchdog_count + 8'h01;
      if (wr_port)
        port_function_select_three <= w_data;
      if (wr_gate)
        module_clock_gate_two <= w_data | `WDR_GATE_RO_MASK;
    end
  end

  // flag survives the overflow reset; the pin reset or a guarded control write with the flag bit at zero clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      reset_occurred_flag <= 1'b0;
    end else if (overflow) begin
      reset_occurred_flag <= 1'b1;
    end else if (wr_ctrl && reg_write_enable && !w_data[`WDR_B_FLAG_INH]
                 && !w_data[`WDR_B_FLAG]) begin
      reset_occurred_flag <= 1'b0;
    end
  end

  // chip reset sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_state    <= ST_IDLE;
      osc_count    <= {`WDR_RST_CNT_W{1'b0}};
      chip_reset_n <= 1'b1;
    end else begin
      case (rst_state)
        ST_IDLE: begin
          if (overflow)
            rst_state <= ST_DELAY;
        end
        ST_DELAY: begin
          if (!base_sub || sub_edge) begin
            rst_state    <= ST_PULSE;
            chip_reset_n <= 1'b0;
            osc_count    <= {`WDR_RST_CNT_W{1'b0}};
          end
        end
        ST_PULSE: begin
          if (osc_edge) begin
            if (osc_count == `WDR_RST_OSC_CYCLES - 1) begin
              rst_state    <= ST_IDLE;
              chip_reset_n <= 1'b1;
            end
            osc_count <= osc_count + 1'b1;
          end
        end
        default: begin
          rst_state    <= ST_IDLE;
          chip_reset_n <= 1'b1;
        end
      endcase
    end
  end

  // read mux
  always @* begin
    case (reg_sel(s_axi_araddr))
      3'h1: rd_val = `WDR_INH_MASK
                     | ({7'h00, count_write_enable} << `WDR_B_CNT_WE)
                     | ({7'h00, reg_write_enable} << `WDR_B_REG_WE)
                     | ({7'h00, watchdog_run} << `WDR_B_RUN)
                     | ({7'h00, reset_occurred_flag} << `WDR_B_FLAG);
      3'h2: rd_val = watchdog_count;
      3'h3: rd_val = port_function_select_three;
      3'h4: rd_val = module_clock_gate_two;
      default: rd_val = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (int_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `WDR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= (reg_sel(s_axi_araddr) == 3'h0) ? `WDR_RESP_SLVERR : `WDR_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // wdr_watchdog

// >>> hdl/wdr_defs.vh
`ifndef WDR_DEFS_VH
`define WDR_DEFS_VH

// register indices; byte address is four times the index
`define WDR_IDX_CTRL        16'hFFB2
`define WDR_IDX_COUNT       16'hFFB3
`define WDR_IDX_PORT_SEL    16'hFFCA
`define WDR_IDX_CLK_GATE    16'hFFFB
`define WDR_ADDR_W          18

// reset values
`define WDR_RST_CTRL        8'hAA
`define WDR_RST_COUNT       8'h00
`define WDR_RST_PORT_SEL    8'h00
`define WDR_RST_CLK_GATE    8'hFF

// control/status field positions
`define WDR_B_CNT_INH       7
`define WDR_B_CNT_WE        6
`define WDR_B_REG_INH       5
`define WDR_B_REG_WE        4
`define WDR_B_RUN_INH       3
`define WDR_B_RUN           2
`define WDR_B_FLAG_INH      1
`define WDR_B_FLAG          0
`define WDR_INH_MASK        8'hAA

// other fields
`define WDR_B_SRC_SEL       5
`define WDR_B_STANDBY       2
`define WDR_GATE_RO_MASK    8'hF0

// timing counts
`define WDR_SYS_DIV         8192
`define WDR_SYS_DIV_W       13
`define WDR_SUB_DIV         32
`define WDR_SUB_DIV_W       5
`define WDR_RST_OSC_CYCLES  512
`define WDR_RST_CNT_W       10

// power modes
`define WDR_MODE_ACTIVE     3'h0
`define WDR_MODE_SLEEP      3'h1
`define WDR_MODE_WATCH      3'h2
`define WDR_MODE_SUBACTIVE  3'h3
`define WDR_MODE_SUBSLEEP   3'h4
`define WDR_MODE_STANDBY    3'h5

// axi responses
`define WDR_RESP_OKAY       2'h0
`define WDR_RESP_SLVERR     2'h2

`endif

// >>> hdl/wdr_pin_sync.v
`include "wdr_defs.vh"

module wdr_pin_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  level,
  output reg  rise
);
  reg s1;
  reg s2;
  reg s3;

  // a change counts only once the second and third stages agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1   <= pin;
      s2   <= s1;
      s3   <= s2;
      rise <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        rise  <= s3 & ~level;
      end
    end
  end
endmodule // wdr_pin_sync

// >>> test/wdr_watchdog_sva.sv
`include "wdr_defs.vh"
module wdr_watchdog_sva (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [`WDR_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   s_axi_awready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   osc_clk_pin,
  input wire logic                   chip_reset_n,
  input wire logic                   module_standby
);
  logic [`WDR_ADDR_W-1:0] raddr_q;
  logic                   osc_q;
  logic [10:0]            osc_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // raw oscillator edges; the design's sync delay is the same at both ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raddr_q <= 18'h0;
      osc_q   <= 1'b0;
      osc_cnt <= 11'h0;
    end else begin
      osc_q <= osc_clk_pin;
      if (s_axi_arvalid && s_axi_arready) raddr_q <= s_axi_araddr;
      if (chip_reset_n) osc_cnt <= 11'h0;
      else if (osc_clk_pin && !osc_q) osc_cnt <= osc_cnt + 11'h1;
    end
  end
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bbusy; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_bbusy: assert property (p_bbusy) else $error("address taken during response");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_inh; s_axi_rvalid && raddr_q == {`WDR_IDX_CTRL, 2'b00}
    |-> (s_axi_rdata[7:0] & `WDR_INH_MASK) == `WDR_INH_MASK; endproperty
  a_inh: assert property (p_inh) else $error("inhibit bit read as zero");
  property p_rstval; $rose(aresetn) |-> chip_reset_n && !module_standby; endproperty
  a_rstval: assert property (p_rstval) else $error("bad state after reset");
  property p_len; $rose(chip_reset_n) |-> osc_cnt >= 11'h1FE && osc_cnt <= 11'h202;
  endproperty
  a_len: assert property (p_len) else $error("chip reset length wrong");
  property p_whole; !chip_reset_n && !$past(chip_reset_n) |-> !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_whole: assert property (p_whole) else $error("bus alive in chip reset");
endmodule // wdr_watchdog_sva
bind wdr_watchdog wdr_watchdog_sva chk_u (
  .aclk           (aclk),
  .aresetn        (aresetn),
  .s_axi_araddr   (s_axi_araddr),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rdata    (s_axi_rdata),
  .s_axi_rresp    (s_axi_rresp),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .s_axi_awready  (s_axi_awready),
  .s_axi_bresp    (s_axi_bresp),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .osc_clk_pin    (osc_clk_pin),
  .chip_reset_n   (chip_reset_n),
  .module_standby (module_standby)
);

// >>> test/tb_watchdog_reset_timer.sv
`include "wdr_defs.vh"
module tb_watchdog_reset_timer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [17:0] A_CTRL = {`WDR_IDX_CTRL, 2'b00};
  localparam logic [17:0] A_CNT  = {`WDR_IDX_COUNT, 2'b00};
  localparam logic [17:0] A_PSEL = {`WDR_IDX_PORT_SEL, 2'b00};
  localparam logic [17:0] A_GATE = {`WDR_IDX_CLK_GATE, 2'b00};
  logic aclk = 0, aresetn = 0, sub_clk = 0, osc_clk = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, chip_reset_n, module_standby;
  logic [1:0] bresp, rresp;
  logic [2:0] power_mode = `WDR_MODE_ACTIVE;
  int n_mismatch = 0, checked = 0;
  wdr_watchdog dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sub_clk_pin(sub_clk),
    .osc_clk_pin(osc_clk), .power_mode(power_mode), .chip_reset_n(chip_reset_n),
    .module_standby(module_standby));
  initial forever #2.5 aclk = ~aclk;
  // slow pins, unrelated in phase to aclk
  initial begin #3.3; forever #20 sub_clk = ~sub_clk; end
  initial begin #7.1; forever #20 osc_clk = ~osc_clk; end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [17:0] a, input logic [7:0] d);
    logic da, dw;
    da = 0;
    dw = 0;
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(da && dw)) begin
      @(posedge aclk);
      if (!da && awready) begin da = 1; awvalid <= 0; end
      if (!dw && wready) begin dw = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(bresp, `WDR_RESP_OKAY);
  endtask
  task rd(input logic [17:0] a, input logic [7:0] exp, input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h0, exp});
    chk(rresp, er);
  endtask
  // overflow must land inside a tick window, then the reset pulse is timed
  task ovf(input int lo, input int hi);
    int i;
    i = 0;
    while (chip_reset_n === 1'b1 && i < hi) begin @(posedge aclk); i++; end
    chk(i > lo && chip_reset_n === 1'b0, 1);
    i = 0;
    while (chip_reset_n === 1'b0 && i < 5000) begin @(posedge aclk); i++; end
    chk(i > 4080 && i < 4112, 1);
    repeat (2) @(posedge aclk);
  endtask
  task end_of_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(A_CTRL, 8'hAA, `WDR_RESP_OKAY);
    rd(A_CNT, 8'h00, `WDR_RESP_OKAY);
    rd(A_GATE, 8'hFF, `WDR_RESP_OKAY);
    rd(A_PSEL, 8'h00, `WDR_RESP_OKAY);
    rd(18'h0, 8'h00, `WDR_RESP_SLVERR);
    wr(A_CTRL, 8'h04);
    rd(A_CTRL, 8'hAA, `WDR_RESP_OKAY);
    wr(A_CNT, 8'h55);
    rd(A_CNT, 8'h00, `WDR_RESP_OKAY);
    wr(A_CTRL, 8'hFF);
    rd(A_CTRL, 8'hAA, `WDR_RESP_OKAY);
    wr(A_CTRL, 8'h50);
    rd(A_CTRL, 8'hFA, `WDR_RESP_OKAY);
    wr(A_CNT, 8'hFE);
    rd(A_CNT, 8'hFE, `WDR_RESP_OKAY);
    wr(A_CTRL, 8'h56);
    rd(A_CTRL, 8'hFE, `WDR_RESP_OKAY);
    ovf(8190, 16420);
    rd(A_CTRL, 8'hAB, `WDR_RESP_OKAY);
    rd(A_CNT, 8'h00, `WDR_RESP_OKAY);
    // first write only opens the guard; the flag needs a second one
    wr(A_CTRL, 8'h50);
    rd(A_CTRL, 8'hFB, `WDR_RESP_OKAY);
    wr(A_CTRL, 8'h50);
    rd(A_CTRL, 8'hFA, `WDR_RESP_OKAY);
    wr(A_GATE, 8'hFB);
    chk(module_standby, 1);
    wr(A_PSEL, 8'h20);
    wr(A_CNT, 8'hFE);
    // watch mode holds the count even while running
    power_mode <= `WDR_MODE_WATCH;
    wr(A_CTRL, 8'h56);
    chk(module_standby, 0);
    repeat (600) @(posedge aclk);
    rd(A_CNT, 8'hFE, `WDR_RESP_OKAY);
    power_mode <= `WDR_MODE_SUBACTIVE;
    ovf(250, 540);
    rd(A_GATE, 8'hFF, `WDR_RESP_OKAY);
    rd(A_CTRL, 8'hAB, `WDR_RESP_OKAY);
    // pin reset after the overflow, with the watchdog stopped, clears the flag
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(A_CTRL, 8'hAA, `WDR_RESP_OKAY);
    end_of_test;
  end
endmodule // tb_watchdog_reset_timer
